// ---- rtl/load_current_consts.vh ----
// What this block does
// - Core-3 limit mask at bit 4, resets 1
// - Core-2 limit mask at bit 0, resets 1
// - Mask gates interrupt only, status stays live
// - Select field bits 1:0 picks core, reset 00
// - Each select write starts a new measurement
// - Master selected: report master plus slaves sum
// - Slave selected: report only its own current
// - High result holds bits 9:8, rest zero
// - Low result holds bits 7:0, read only
// - Measurement done raises maskable ready event
`ifndef LOAD_CURRENT_CONSTS_VH
`define LOAD_CURRENT_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_ILIM_MASK      8'h20
`define OFS_MEAS_SELECT    8'h21
`define OFS_RESULT_HIGH    8'h22
`define OFS_RESULT_LOW     8'h23

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CORE3_MASK_BIT     4
`define CORE2_MASK_BIT     0
`define CORE3_MASK_RST     1'h1
`define CORE2_MASK_RST     1'h1
`define SELECT_RST         2'h0
`define RESULT_RST         10'h000

// ----------------------------------------------------------------
// Measurement sizing and timing
// ----------------------------------------------------------------
`define RESULT_W           10
`define SAMPLE_W           10
`define SUM_W              12
`define RESULT_FULL        10'h3ff
`define AVG_SHIFT_DEFAULT  4

`endif

// ---- rtl/load_average.v ----
`default_nettype none
`include "load_current_consts.vh"

module load_average #(
	parameter AVG_SHIFT = `AVG_SHIFT_DEFAULT
) (
	// Clock, reset, enable
	input  wire                    clk,
	input  wire                    rst,
	input  wire                    ce,
	// Control
	input  wire                    start,
	// Sample stream
	input  wire                    sample_valid,
	input  wire [`SUM_W-1:0]       sample,
	// Result
	output reg  [`RESULT_W-1:0]    result_ff,
	output reg                     done_ff,
	output reg                     busy_ff
);

	localparam ACC_W = `SUM_W + AVG_SHIFT;

	reg  [ACC_W-1:0]      acc_ff;
	reg  [AVG_SHIFT:0]    cnt_ff;
	wire [ACC_W-1:0]      acc_sum;
	wire [`SUM_W-1:0]     mean;

	assign acc_sum = acc_ff + {{AVG_SHIFT{1'b0}}, sample};
	assign mean    = acc_sum[ACC_W-1:AVG_SHIFT];

	// ------------------------------------------------------------
	// Accumulate 2**AVG_SHIFT samples, then saturate to 10 bits
	// ------------------------------------------------------------
	// A start restarts the window even mid-run, old result held
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_ff    <= {ACC_W{1'b0}};
			cnt_ff    <= {(AVG_SHIFT+1){1'b0}};
			result_ff <= `RESULT_RST;
			done_ff   <= 1'b0;
			busy_ff   <= 1'b0;
		end else if (ce) begin
			done_ff <= 1'b0;
			if (start) begin
				acc_ff  <= {ACC_W{1'b0}};
				cnt_ff  <= {(AVG_SHIFT+1){1'b0}};
				busy_ff <= 1'b1;
			end else if (busy_ff && sample_valid) begin
				if (cnt_ff == (1 << AVG_SHIFT) - 1) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
					// Clip: a summed phase group can pass 20 A
					if (mean > {2'h0, `RESULT_FULL})
						result_ff <= `RESULT_FULL;
					else
						result_ff <= mean[`RESULT_W-1:0];
				end else begin
					acc_ff <= acc_sum;
					cnt_ff <= cnt_ff + 1'b1;
				end
			end
		end
	end

endmodule

`default_nettype wire

// ---- rtl/load_current_readout_and_ilim_mask.v ----
`default_nettype none
`include "load_current_consts.vh"

module load_current_readout_and_ilim_mask #(
	parameter AVG_SHIFT = `AVG_SHIFT_DEFAULT
) (
	// Clock, reset, enable
	input  wire                      clk,
	input  wire                      rst,
	input  wire                      ce,
	// Register access from the serial control interface
	input  wire [7:0]                reg_addr,
	input  wire                      reg_wr,
	input  wire [7:0]                reg_wdata,
	input  wire                      reg_rd,
	output reg  [7:0]                reg_rdata_ff,
	// Raw current-limit detections, asynchronous
	input  wire                      core2_limit_in,
	input  wire                      core3_limit_in,
	// Phase configuration and per-core samples
	input  wire [3:0]                core_is_master,
	input  wire [7:0]                core_master_map,
	input  wire                      sample_valid,
	input  wire [4*`SAMPLE_W-1:0]    core_samples,
	// Ready mask held in the top-level mask register
	input  wire                      load_ready_mask,
	// Status and interrupt events
	output reg                       core2_limit_raw_status_ff,
	output reg                       core3_limit_raw_status_ff,
	output reg                       core2_limit_irq_ff,
	output reg                       core3_limit_irq_ff,
	output reg                       load_ready_irq_ff,
	output reg                       measure_busy_ff
);

	// ------------------------------------------------------------
	// Phase sum selection
	// ------------------------------------------------------------
	// Master: its own sample plus every core mapped to it.
	// Slave: own sample only.
	function [`SUM_W-1:0] phase_sum;
		input [1:0]              sel;
		input [3:0]              masters;
		input [7:0]              map;
		input [4*`SAMPLE_W-1:0]  smp;
		integer                  i;
		reg   [`SUM_W-1:0]       acc;
		begin
			acc = {2'h0, smp[sel*`SAMPLE_W +: `SAMPLE_W]};
			if (masters[sel]) begin
				for (i = 0; i < 4; i = i + 1) begin
					if (i != sel && map[2*i +: 2] == sel)
						acc = acc + {2'h0,
							smp[i*`SAMPLE_W +: `SAMPLE_W]};
				end
			end
			phase_sum = acc;
		end
	endfunction

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// Shared by the write strobes and the read mux, so both sides
	// of the bus agree on which offset is which register
	function addr_hit;
		input [7:0]              addr;
		input [7:0]              ofs;
		begin
			addr_hit = (addr == ofs);
		end
	endfunction

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Programmable storage; reserved bits have no flops
	reg                    core3_mask_ff;
	reg                    core2_mask_ff;
	reg  [1:0]             select_ff;
	reg                    start_ff;
	// Completed measurement as the host sees it
	reg  [`RESULT_W-1:0]   result_ff;
	// Limit line synchroniser stages
	reg  [1:0]             sync1_ff;
	reg  [1:0]             sync2_ff;
	// Averager hookup
	wire [`SUM_W-1:0]      sel_sample;
	wire [`RESULT_W-1:0]   avg_result;
	wire                   avg_done;
	wire                   avg_busy;
	// Bus decode
	wire                   wr_mask;
	wire                   wr_select;
	reg  [7:0]             nxt_rdata;

	// Write strobes; the result offsets get none, so read-only
	assign wr_mask   = reg_wr && addr_hit(reg_addr, `OFS_ILIM_MASK);
	assign wr_select = reg_wr && addr_hit(reg_addr, `OFS_MEAS_SELECT);

	// Mask and select storage; reserved bits are not stored
	// A select write also arms start, one pulse per write
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			core3_mask_ff <= `CORE3_MASK_RST;
			core2_mask_ff <= `CORE2_MASK_RST;
			select_ff     <= `SELECT_RST;
			start_ff      <= 1'b0;
		end else if (ce) begin
			start_ff <= wr_select;
			if (wr_mask) begin
				core3_mask_ff <= reg_wdata[`CORE3_MASK_BIT];
				core2_mask_ff <= reg_wdata[`CORE2_MASK_BIT];
			end
			if (wr_select)
				select_ff <= reg_wdata[1:0];
		end
	end

	// ------------------------------------------------------------
	// Measurement
	// ------------------------------------------------------------
	// Config and samples share clk, so they need no synchroniser
	// Sum computed on the live select so the new core is used
	assign sel_sample = phase_sum(select_ff, core_is_master,
		core_master_map, core_samples);

	load_average #(
		.AVG_SHIFT    (AVG_SHIFT)
	) u_avg (
		.clk          (clk),
		.rst          (rst),
		.ce           (ce),
		.start        (start_ff),
		.sample_valid (sample_valid),
		.sample       (sel_sample),
		.result_ff    (avg_result),
		.done_ff      (avg_done),
		.busy_ff      (avg_busy)
	);

	// Result capture and ready event
	// Busy also covers the start cycle, so the host sees no gap
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			result_ff         <= `RESULT_RST;
			load_ready_irq_ff <= 1'b0;
			measure_busy_ff   <= 1'b0;
		end else if (ce) begin
			measure_busy_ff   <= avg_busy | start_ff;
			load_ready_irq_ff <= avg_done & ~load_ready_mask;
			if (avg_done)
				result_ff <= avg_result;
		end
	end

	// ------------------------------------------------------------
	// Current-limit inputs
	// ------------------------------------------------------------
	// Two-stage synchroniser; stage one feeds stage two only
	// Limit pulses shorter than a clock may be missed
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_ff <= 2'h0;
			sync2_ff <= 2'h0;
		end else if (ce) begin
			sync1_ff <= {core3_limit_in, core2_limit_in};
			sync2_ff <= sync1_ff;
		end
	end

	// Status follows the line whatever the mask says
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			core2_limit_raw_status_ff <= 1'b0;
			core3_limit_raw_status_ff <= 1'b0;
			core2_limit_irq_ff        <= 1'b0;
			core3_limit_irq_ff        <= 1'b0;
		end else if (ce) begin
			core2_limit_raw_status_ff <= sync2_ff[0];
			core3_limit_raw_status_ff <= sync2_ff[1];
			// Event on a new detection only, gated by the mask
			// Unmasking during a held limit waits for the next rise
			core2_limit_irq_ff <= sync2_ff[0] &
				~core2_limit_raw_status_ff & ~core2_mask_ff;
			core3_limit_irq_ff <= sync2_ff[1] &
				~core3_limit_raw_status_ff & ~core3_mask_ff;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Unmapped and reserved bits read as zero
	always @* begin
		nxt_rdata = 8'h00;
		if (addr_hit(reg_addr, `OFS_ILIM_MASK)) begin
			// Only the two mask flops exist here
			nxt_rdata[`CORE3_MASK_BIT] = core3_mask_ff;
			nxt_rdata[`CORE2_MASK_BIT] = core2_mask_ff;
		end else if (addr_hit(reg_addr, `OFS_MEAS_SELECT)) begin
			// Core of the latest measurement request
			nxt_rdata[1:0] = select_ff;
		end else if (addr_hit(reg_addr, `OFS_RESULT_HIGH)) begin
			// Top two result bits, upper six stay zero
			nxt_rdata[1:0] = result_ff[9:8];
		end else if (addr_hit(reg_addr, `OFS_RESULT_LOW)) begin
			// Low byte of the same stored result
			nxt_rdata = result_ff[7:0];
		end
	end

	// ------------------------------------------------------------
	// Read data register
	// ------------------------------------------------------------
	// Read data held until the next read; a read while ce is
	// low is lost and the host has to repeat it
	always @(posedge clk or posedge rst) begin
		if (rst)
			reg_rdata_ff <= 8'h00;
		else if (ce && reg_rd)
			reg_rdata_ff <= nxt_rdata;
	end

endmodule

`default_nettype wire

// ---- bench/lc_checker.sv ----
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module lc_checker (
	// Clock and register bus
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       reg_rd,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata_ff,
	// Limits and measurement
	input wire logic       core2_limit_in,
	input wire logic       core2_limit_raw_status_ff,
	input wire logic       core2_limit_irq_ff,
	input wire logic       core3_limit_raw_status_ff,
	input wire logic       core3_limit_irq_ff,
	input wire logic       sample_valid,
	input wire logic       load_ready_mask,
	input wire logic       load_ready_irq_ff,
	input wire logic       measure_busy_ff
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Pulses only on a fresh status rise; guard skips reset history
	a_irq2_on_rise: assert property (core2_limit_irq_ff |->
		$rose(core2_limit_raw_status_ff)) else $error("irq2 without rise");
	a_irq3_on_rise: assert property (core3_limit_irq_ff |->
		$rose(core3_limit_raw_status_ff)) else $error("irq3 without rise");
	a_status_tracks: assert property (!$past(rst, 3) && !$past(rst, 2)
		&& !$past(rst) |-> core2_limit_raw_status_ff == $past(core2_limit_in, 3))
		else $error("status lost track");
	a_ready_masked: assert property (load_ready_irq_ff |->
		!$past(load_ready_mask)) else $error("ready irq while masked");
	a_ready_ends_busy: assert property (load_ready_irq_ff |->
		$fell(measure_busy_ff)) else $error("ready irq off busy fall");
	a_done_after_sample: assert property ($fell(measure_busy_ff) |->
		$past(sample_valid, 2)) else $error("done without sample");
	a_select_starts: assert property (reg_wr && reg_addr == 8'h21 |->
		##[1:3] measure_busy_ff) else $error("select write no start");
	a_high_reserved: assert property ($past(reg_rd) &&
		$past(reg_addr) == 8'h22 |-> reg_rdata_ff[7:2] == 6'h00)
		else $error("high result reserved set");
	a_unmapped_zero: assert property ($past(reg_rd) && ($past(reg_addr) <
		8'h20 || $past(reg_addr) > 8'h23) |-> reg_rdata_ff == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind load_current_readout_and_ilim_mask lc_checker chk_u (.clk, .rst,
	.reg_rd, .reg_wr, .reg_addr, .reg_rdata_ff, .core2_limit_in,
	.core2_limit_raw_status_ff, .core2_limit_irq_ff, .core3_limit_irq_ff,
	.core3_limit_raw_status_ff, .sample_valid, .load_ready_mask,
	.load_ready_irq_ff, .measure_busy_ff);
`default_nettype wire

// ---- bench/lc_host.sv ----
`default_nettype none
// ----------------------------------------
// Host side of the register bus
// ----------------------------------------
module lc_host (
	// Clock
	input wire logic       clk,
	// Register strobes
	output logic [7:0]     reg_addr,
	output logic           reg_wr,
	output logic [7:0]     reg_wdata,
	output logic           reg_rd,
	input wire logic [7:0] reg_rdata_ff
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	// One-cycle write; stale data is inverted so nothing leans on it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	// One-cycle read; data stands until the next read
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_ff;
	endtask
endmodule
`default_nettype wire

// ---- bench/load_current_readout_and_ilim_mask_tb_top.sv ----
`default_nettype none
// ----------------------------------------
// Bench top
// ----------------------------------------
module load_current_readout_and_ilim_mask_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, sample_valid = 1'b0;
	logic c2 = 1'b0, c3 = 1'b0, rmask = 1'b0, s2, s3, i2, i3, ri, busy;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, d, hi, map = 8'ha0;
	logic [3:0] mst = 4'h5;
	logic [39:0] smp = 40'h0;
	logic [1:0] cyc = 2'h0;
	logic reg_wr, reg_rd;
	integer seed = 32'h750354e5, bad_count = 0, samples_checked = 0;
	integer n2 = 0, n3 = 0, nr = 0, k, t, m, sel;
	lc_host host_u (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
		.reg_rdata_ff);
	load_current_readout_and_ilim_mask #(.AVG_SHIFT(1)) dut_u (.clk, .rst,
		.ce, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata_ff,
		.core2_limit_in(c2), .core3_limit_in(c3), .core_is_master(mst),
		.core_master_map(map), .sample_valid, .core_samples(smp),
		.load_ready_mask(rmask), .core2_limit_raw_status_ff(s2),
		.core3_limit_raw_status_ff(s3), .core2_limit_irq_ff(i2),
		.core3_limit_irq_ff(i3), .load_ready_irq_ff(ri),
		.measure_busy_ff(busy));
	always #20 clk = ~clk;
	// Sample pulse every fourth cycle, pulses counted as seen
	always @(posedge clk) begin
		cyc <= cyc + 2'h1;
		sample_valid <= cyc == 2'h0;
		if (i2 === 1'b1) n2 <= n2 + 1;
		if (i3 === 1'b1) n3 <= n3 + 1;
		if (ri === 1'b1) nr <= nr + 1;
	end
	task automatic check(input string nm, input logic [15:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Master sums its slaves; a slave reports itself, clipped to 10 bits
	function automatic logic [9:0] want(input integer s);
		logic [11:0] sum;
		sum = 12'(smp[10*s+:10]);
		for (int i = 0; i < 4; i++)
			if (mst[s] && i != s && map[2*i+:2] == 2'(s))
				sum = sum + 12'(smp[10*i+:10]);
		return (sum > 12'h3ff) ? 10'h3ff : sum[9:0];
	endfunction
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		host_u.wr(8'h23, 8'h5a);
		// Reset values, then an unmapped place
		for (k = 0; k < 5; k++) begin
			host_u.rd(8'(8'h20 + k), d);
			check("reset", 16'(d), k == 0 ? 16'h11 : 16'h0);
		end
		// A write while the enable is low must leave the masks alone
		@(posedge clk);
		ce <= 1'b0;
		host_u.wr(8'h20, 8'h00);
		ce <= 1'b1;
		host_u.rd(8'h20, d);
		check("freeze", 16'(d), 16'h11);
		// Mask cleared through reserved bits, then set
		for (k = 0; k < 2; k++) begin
			host_u.wr(8'h20, k ? 8'hff : 8'hee);
			host_u.rd(8'h20, d);
			check("mask", 16'(d), k ? 16'h11 : 16'h0);
			m = n2 + n3;
			@(posedge clk);
			c2 <= 1'b1;
			c3 <= 1'b1;
			repeat (5) @(posedge clk);
			check("status", 16'({s3, s2}), 16'h3);
			check("irq", 16'(n2 + n3 - m), k ? 16'h0 : 16'h2);
			c2 <= 1'b0;
			c3 <= 1'b0;
			repeat (5) @(posedge clk);
		end
		// Random cores and loads, each run restarted back to back
		for (k = 0; k < 10; k++) begin
			@(posedge clk);
			sel = $random(seed) & 3;
			smp <= 40'({$random(seed), $random(seed)});
			mst <= 4'($random(seed));
			rmask <= k == 5;
			m = nr;
			host_u.wr(8'h21, 8'(3 - sel));
			host_u.wr(8'h21, 8'($random(seed)) & 8'hfc | 8'(sel));
			host_u.rd(8'h21, d);
			check("select", 16'(d), 16'(sel));
			for (t = 0; t < 400 && busy !== 1'b0; t++)
				@(posedge clk);
			check("timeout", 16'(t == 400), 16'h0);
			if (t == 400)
				wrap_up;
			// Pulse counter updates on the same edge busy is seen low, too late to read then
			@(posedge clk);
			check("ready", 16'(nr - m), k == 5 ? 16'h0 : 16'h1);
			host_u.rd(8'h22, hi);
			host_u.rd(8'h23, d);
			check("result", {hi, d}, 16'(want(sel)));
		end
		wrap_up;
	end
endmodule
`default_nettype wire
